//--- rtl/prt_top.sv
// Power-down, start-up, standby, overheat, timers and register file.
// Assumes single-cycle register strobes from the host decoder
// and pin inputs synchronous to clk_sys.
//
// Notes on behaviour
// - Reset pin low: regulators, oscillator low, inputs clamped
// - Power-down: pull-downs on four outputs, rest high-Z
// - Reset pin must stay low ten microseconds
// - Reset release runs start-up, registers to defaults
// - Soft reset bit clears registers, no low power
// - Idle flag raised in the same cycle that host commands become accepted
// - Card emulation is the default after power-up
// - Standby command enters standby, current sinks off
// - Standby keeps inputs live, outputs hold level
// - Standby loses registers except pad and thermal
// - Wake on timer, RF level, reset, supply loss
// - Host activity in standby starts start-up sequence
// - Thermal setup picks one of four thresholds
// - Overheat switches RF off and sets flag
// - Overheat monitored outside power-down; only mask is settable
// - Three 20-bit timers from divided 13.56 MHz tick
// - Timers start on events, reload, flag on expiry
// - Eight prescaler rates halving from 6.78 MHz
// - Noise handling restarts timer one; timer two reserved during authentication
// - Pin active while any enabled flag stays set
// - Flags always record; clear by write or read
// - Three interrupts unmaskable; pin polarity configurable
`timescale 1ns/10ps
`default_nettype none
module prt_top #(
  parameter int unsigned STARTUP_CYC = prt_pkg::PRT_STARTUP_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic host_io_supply_ok,
  input wire logic host_activity,
  input wire logic standby_cmd,
  input wire logic base_tick,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire prt_pkg::prt_rf_ev_s rf_ev,
  input wire logic rf_level_det,
  input wire logic noise_event,
  input wire logic auth_active,
  input wire logic [7:0] temp_deg,
  input wire logic card_detect_interrupt,
  input wire logic general_error_ev,
  input wire logic high_voltage_fault_interrupt,
  input wire logic clear_on_read_cfg,
  input wire logic irq_active_high_cfg,
  output logic [31:0] reg_rdata,
  output logic host_ready,
  output logic busy,
  output logic irq_pin,
  output logic regulators_low_power,
  output logic inputs_clamped,
  output logic [3:0] pulldown_en,
  output logic outputs_hiz,
  output logic sinks_low_power,
  output logic outputs_hold,
  output logic card_mode,
  output logic rf_field_on,
  output logic [31:0] pad_setup,
  output logic [31:0] pad_output_levels
);
  import prt_pkg::*;

  // ==========================================================
  // Declarations
  prt_state_e st_q, st_d;
  logic [PRT_QUAL_W-1:0] low_q, low_d;
  logic [15:0] su_q, su_d;
  logic [19:0] wcnt_q, wcnt_d;
  logic [1:0] wen_q, wen_d;
  logic [31:0] cc_q, cc_d, sw_q, sw_d, noise_q, noise_d;
  prt_retain_s keep_q, keep_d;
  logic qual, clr_all, clr_stby, clr_any, idle_ev, wake;
  logic wr_ok, rd_ok, soft_rst, hot;
  logic [31:0] rd_d, rd_q;
  logic ready_q, ready_d;
  logic [7:0] out_q, out_d;
  logic [7:0] irq_ev, irq_stat, irq_en;
  logic [2:0] tmr_exp;
  logic [31:0] tmr_cfg [3];
  logic [19:0] tmr_rel [3];
  logic [19:0] tmr_val [3];
  logic [2:0] tcfg_wr, trel_wr, trestart;

  // ==========================================================
  // Reset pin qualification
  assign qual = (low_q == PRT_QUAL_W'(PRT_RST_QUAL_CYC));

  // Count low cycles on the reset pin
  always_comb begin
    if (reset_pin_n) begin
      low_d = '0;
    end else if (qual) begin
      low_d = low_q;
    end else begin
      low_d = low_q + PRT_QUAL_W'(1);
    end
  end

  // ==========================================================
  // Sequencer
  assign wr_ok = reg_wr && (st_q == PRT_ACTIVE);
  assign rd_ok = reg_rd && (st_q == PRT_ACTIVE);
  assign soft_rst = wr_ok && (reg_addr == PRT_ADR_CHIP_CTRL) && reg_wdata[PRT_CC_SOFT_RST];
  assign wake = (wen_q[PRT_SW_TIMER] && (wcnt_q == 20'h0))
    || (wen_q[PRT_SW_RF] && rf_level_det)
    || !reset_pin_n || !host_io_supply_ok || host_activity;

  // State transitions, clear requests and standby wake timer
  always_comb begin
    st_d = st_q;
    su_d = su_q;
    wcnt_d = wcnt_q;
    wen_d = wen_q;
    clr_all = 1'b0;
    clr_stby = 1'b0;
    idle_ev = 1'b0;
    case (st_q)
      PRT_PWRDN: begin
        if (reset_pin_n) begin
          st_d = PRT_STARTUP;
          su_d = 16'h0;
          clr_all = 1'b1;
        end
      end
      PRT_STARTUP: begin
        if (qual) begin
          st_d = PRT_PWRDN;
        end else if (su_q == 16'(STARTUP_CYC - 1)) begin
          st_d = PRT_ACTIVE;
          idle_ev = 1'b1;
        end else begin
          su_d = su_q + 16'h1;
        end
      end
      PRT_ACTIVE: begin
        if (qual) begin
          st_d = PRT_PWRDN;
        end else if (standby_cmd) begin
          st_d = PRT_STANDBY;
          clr_stby = 1'b1;
          wen_d = sw_q[1:0];
          wcnt_d = sw_q[PRT_SW_CNT_LSB +: 20];
        end else if (soft_rst) begin
          clr_all = 1'b1;
        end
      end
      PRT_STANDBY: begin
        if (base_tick && (wcnt_q != 20'h0)) begin
          wcnt_d = wcnt_q - 20'h1;
        end
        if (wake) begin
          st_d = PRT_STARTUP;
          su_d = 16'h0;
          wen_d = 2'h0;
        end
      end
      default: begin
        st_d = PRT_STARTUP;
        su_d = 16'h0;
        clr_all = 1'b1;
      end
    endcase
  end

  assign clr_any = clr_all || clr_stby;

  // ==========================================================
  // Register file
  assign hot = temp_deg > prt_thresh(keep_q.thermal[1:0]);

  // Register writes and discards
  always_comb begin
    cc_d = cc_q;
    sw_d = sw_q;
    noise_d = noise_q;
    keep_d = keep_q;
    if (wr_ok) begin
      case (reg_addr)
        PRT_ADR_CHIP_CTRL: cc_d = {reg_wdata[31:9], 1'b0, reg_wdata[7:0]};
        PRT_ADR_PAD_SETUP: keep_d.pad_setup = reg_wdata;
        PRT_ADR_PAD_OUT: keep_d.pad_out = reg_wdata;
        PRT_ADR_THERMAL: keep_d.thermal = reg_wdata;
        PRT_ADR_SLEEP_WAKE: sw_d = reg_wdata;
        PRT_ADR_NOISE: noise_d = reg_wdata;
        default: cc_d = cc_q;
      endcase
    end
    if (hot) begin
      cc_d[PRT_CC_RF_ON] = 1'b0;
    end
    if (clr_any) begin
      cc_d = PRT_RST_VAL;
      sw_d = PRT_RST_VAL;
      noise_d = PRT_RST_VAL;
    end
    if (clr_all) begin
      keep_d = {3{PRT_RST_VAL}};
    end
  end

  // Read data mux
  always_comb begin
    rd_d = rd_q;
    if (rd_ok) begin
      case (reg_addr)
        PRT_ADR_CHIP_CTRL: rd_d = cc_q;
        PRT_ADR_IRQ_EN: rd_d = {24'h0, irq_en};
        PRT_ADR_IRQ_STAT: rd_d = {24'h0, irq_stat};
        PRT_ADR_PAD_SETUP: rd_d = keep_q.pad_setup;
        PRT_ADR_PAD_OUT: rd_d = keep_q.pad_out;
        PRT_ADR_THERMAL: rd_d = keep_q.thermal;
        PRT_ADR_SLEEP_WAKE: rd_d = sw_q;
        PRT_ADR_NOISE: rd_d = noise_q;
        default: rd_d = 32'h0;
      endcase
      for (int i = 0; i < 3; i++) begin
        if (reg_addr == prt_tmr_adr(i, 0)) rd_d = tmr_cfg[i];
        if (reg_addr == prt_tmr_adr(i, 1)) rd_d = {12'h0, tmr_rel[i]};
        if (reg_addr == prt_tmr_adr(i, 2)) rd_d = {12'h0, tmr_val[i]};
      end
    end
  end

  // ==========================================================
  // Pin controls per power state
  always_comb begin
    ready_d = (st_d == PRT_ACTIVE);
    out_d = 8'h0;
    case (st_d)
      PRT_PWRDN: out_d = 8'b0000_0111;
      PRT_STANDBY: out_d = 8'b0001_1000;
      default: out_d = 8'h0;
    endcase
    out_d[5] = !cc_d[PRT_CC_READER];
    out_d[6] = cc_d[PRT_CC_RF_ON] && !hot && (st_d == PRT_ACTIVE);
    out_d[7] = !ready_d;
  end

  // Sequencer and register state
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q <= PRT_STARTUP;
      low_q <= '0;
      su_q <= 16'h0;
      wcnt_q <= 20'h0;
      wen_q <= 2'h0;
      cc_q <= PRT_RST_VAL;
      sw_q <= PRT_RST_VAL;
      noise_q <= PRT_RST_VAL;
      keep_q <= '0;
      rd_q <= 32'h0;
      ready_q <= 1'b0;
      out_q <= 8'ha0;
    end else begin
      st_q <= st_d;
      low_q <= low_d;
      su_q <= su_d;
      wcnt_q <= wcnt_d;
      wen_q <= wen_d;
      cc_q <= cc_d;
      sw_q <= sw_d;
      noise_q <= noise_d;
      keep_q <= keep_d;
      rd_q <= rd_d;
      ready_q <= ready_d;
      out_q <= out_d;
    end
  end

  // ==========================================================
  // Timers
  generate
    for (genvar g = 0; g < 3; g++) begin : g_tmr
      // Timer two is closed to host writes during authentication
      assign tcfg_wr[g] = wr_ok && (reg_addr == prt_tmr_adr(g, 0))
        && !(g == 2 && auth_active);
      assign trel_wr[g] = wr_ok && (reg_addr == prt_tmr_adr(g, 1))
        && !(g == 2 && auth_active);
      assign trestart[g] = (g == 1) && noise_q[PRT_NOISE_ON] && noise_event;

      prt_timer u_tmr (
        .clk_sys(clk_sys),
        .reset(reset),
        .clr(clr_any),
        .base_tick(base_tick),
        .cfg_wr(tcfg_wr[g]),
        .reload_wr(trel_wr[g]),
        .wdata(reg_wdata),
        .rf_ev(rf_ev),
        .restart(trestart[g]),
        .cfg(tmr_cfg[g]),
        .reload(tmr_rel[g]),
        .value(tmr_val[g]),
        .expired(tmr_exp[g])
      );
    end
  endgenerate

  // ==========================================================
  // Interrupts
  always_comb begin
    irq_ev = 8'h0;
    irq_ev[PRT_IRQ_IDLE] = idle_ev;
    irq_ev[PRT_IRQ_TMR0 +: 3] = tmr_exp;
    irq_ev[PRT_IRQ_OVERHEAT] = hot && (st_q != PRT_PWRDN);
    irq_ev[PRT_IRQ_CARD_DET] = card_detect_interrupt;
    irq_ev[PRT_IRQ_GEN_ERR] = general_error_ev;
    irq_ev[PRT_IRQ_HV_ERR] = high_voltage_fault_interrupt;
  end

  prt_irq u_irq (
    .clk_sys(clk_sys),
    .reset(reset),
    .clr(clr_any),
    .events(irq_ev),
    .en_wr(wr_ok && (reg_addr == PRT_ADR_IRQ_EN)),
    .clr_wr(wr_ok && (reg_addr == PRT_ADR_IRQ_CLR)),
    .stat_rd(rd_ok && (reg_addr == PRT_ADR_IRQ_STAT)),
    .wdata(reg_wdata[7:0]),
    .clear_on_read(clear_on_read_cfg),
    .irq_active_high(irq_active_high_cfg),
    .status(irq_stat),
    .enable(irq_en),
    .irq_pin(irq_pin)
  );

  // ==========================================================
  // Outputs
  assign reg_rdata = rd_q;
  assign host_ready = ready_q;
  assign regulators_low_power = out_q[0];
  assign inputs_clamped = out_q[0];
  assign pulldown_en = {4{out_q[1]}};
  assign outputs_hiz = out_q[2];
  assign sinks_low_power = out_q[3];
  assign outputs_hold = out_q[4];
  assign card_mode = out_q[5];
  assign rf_field_on = out_q[6];
  assign busy = out_q[7];
  assign pad_setup = keep_q.pad_setup;
  assign pad_output_levels = keep_q.pad_out;
endmodule
`default_nettype wire

//--- rtl/prt_pkg.sv
// Shared constants, types and decoders of the controller.
// Assumes a 125 MHz system clock and a 13.56 MHz tick enable input.
package prt_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned PRT_CLK_KHZ = 125000;
  localparam int unsigned PRT_RST_QUAL_NS = 10000;
  localparam int unsigned PRT_RST_QUAL_CYC = (PRT_RST_QUAL_NS * PRT_CLK_KHZ + 999999) / 1000000;
  localparam int unsigned PRT_STARTUP_CYC_DEF = 64;
  localparam int unsigned PRT_QUAL_W = 11;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] PRT_ADR_CHIP_CTRL = 8'h00;
  localparam logic [7:0] PRT_ADR_IRQ_EN = 8'h01;
  localparam logic [7:0] PRT_ADR_IRQ_STAT = 8'h02;
  localparam logic [7:0] PRT_ADR_IRQ_CLR = 8'h03;
  localparam logic [7:0] PRT_ADR_PAD_SETUP = 8'h05;
  localparam logic [7:0] PRT_ADR_PAD_OUT = 8'h07;
  localparam logic [7:0] PRT_ADR_TMR_BASE = 8'h10;
  localparam logic [7:0] PRT_ADR_THERMAL = 8'h25;
  localparam logic [7:0] PRT_ADR_SLEEP_WAKE = 8'h26;
  localparam logic [7:0] PRT_ADR_NOISE = 8'h28;
  localparam int unsigned PRT_TMR_STRIDE = 3;

  // ==========================================================
  // Field positions and reset values
  localparam int unsigned PRT_CC_READER = 0;
  localparam int unsigned PRT_CC_RF_ON = 1;
  localparam int unsigned PRT_CC_SOFT_RST = 8;
  localparam int unsigned PRT_SW_TIMER = 0;
  localparam int unsigned PRT_SW_RF = 1;
  localparam int unsigned PRT_SW_CNT_LSB = 4;
  localparam int unsigned PRT_NOISE_ON = 0;
  localparam int unsigned PRT_TC_RUN = 0;
  localparam int unsigned PRT_TC_RELOAD = 1;
  localparam int unsigned PRT_TC_PSC_LSB = 4;
  localparam int unsigned PRT_TC_EV_LSB = 8;
  localparam logic [31:0] PRT_RST_VAL = 32'h0000_0000;

  // Start events of a timer
  localparam logic [2:0] PRT_EV_NOW = 3'h0;
  localparam logic [2:0] PRT_EV_FIELD_ON = 3'h1;
  localparam logic [2:0] PRT_EV_FIELD_OFF = 3'h2;
  localparam logic [2:0] PRT_EV_RX_START = 3'h3;
  localparam logic [2:0] PRT_EV_RX_END = 3'h4;
  localparam logic [2:0] PRT_EV_TX_START = 3'h5;
  localparam logic [2:0] PRT_EV_TX_END = 3'h6;

  // ==========================================================
  // Interrupt flag positions
  localparam int unsigned PRT_IRQ_N = 8;
  localparam int unsigned PRT_IRQ_IDLE = 0;
  localparam int unsigned PRT_IRQ_TMR0 = 1;
  localparam int unsigned PRT_IRQ_OVERHEAT = 4;
  localparam int unsigned PRT_IRQ_CARD_DET = 5;
  localparam int unsigned PRT_IRQ_GEN_ERR = 6;
  localparam int unsigned PRT_IRQ_HV_ERR = 7;
  localparam logic [7:0] PRT_IRQ_NMI = 8'he0;

  // Overheat thresholds in degrees
  localparam logic [7:0] PRT_TH_85 = 8'h55;
  localparam logic [7:0] PRT_TH_115 = 8'h73;
  localparam logic [7:0] PRT_TH_125 = 8'h7d;
  localparam logic [7:0] PRT_TH_135 = 8'h87;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    PRT_PWRDN = 4'b0001,
    PRT_STARTUP = 4'b0010,
    PRT_ACTIVE = 4'b0100,
    PRT_STANDBY = 4'b1000
  } prt_state_e;

  typedef struct packed {
    logic field_on;
    logic field_off;
    logic rx_start;
    logic rx_end;
    logic tx_start;
    logic tx_end;
  } prt_rf_ev_s;

  typedef struct packed {
    logic [31:0] pad_setup;
    logic [31:0] pad_out;
    logic [31:0] thermal;
  } prt_retain_s;

  // Threshold selected by the thermal limit setup
  function automatic logic [7:0] prt_thresh(input logic [1:0] sel);
    case (sel)
      2'h0: prt_thresh = PRT_TH_85;
      2'h1: prt_thresh = PRT_TH_115;
      2'h2: prt_thresh = PRT_TH_125;
      default: prt_thresh = PRT_TH_135;
    endcase
  endfunction

  // Address of register k of timer i
  function automatic logic [7:0] prt_tmr_adr(input int unsigned i, input int unsigned k);
    prt_tmr_adr = PRT_ADR_TMR_BASE + 8'(PRT_TMR_STRIDE * i + k);
  endfunction

endpackage

//--- rtl/prt_timer.sv
// One general-purpose 20-bit down-counting timer with prescaler.
// Assumes base_tick is one 13.56 MHz pulse in clk_sys.
`timescale 1ns/10ps
`default_nettype none
module prt_timer (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clr,
  input wire logic base_tick,
  input wire logic cfg_wr,
  input wire logic reload_wr,
  input wire logic [31:0] wdata,
  input wire prt_pkg::prt_rf_ev_s rf_ev,
  input wire logic restart,
  output logic [31:0] cfg,
  output logic [19:0] reload,
  output logic [19:0] value,
  output logic expired
);
  import prt_pkg::*;

  logic [31:0] cfg_q, cfg_d;
  logic [19:0] rel_q, rel_d, val_q, val_d;
  logic [7:0] div_q, div_d;
  logic armed_q, armed_d, run_q, run_d, exp_q, exp_d;
  logic [2:0] psc;
  logic [2:0] ev_sel;
  logic [7:0] psc_mask;
  logic tick, ev_hit;

  // ==========================================================
  // Prescaler: rate k divides the base by two to the k plus one
  assign psc = cfg_q[PRT_TC_PSC_LSB +: 3];
  assign psc_mask = 8'((9'h2 << psc) - 9'h1);
  assign tick = base_tick && ((div_q & psc_mask) == psc_mask);
  assign ev_sel = cfg_q[PRT_TC_EV_LSB +: 3];

  // Start event selection
  always_comb begin
    case (ev_sel)
      PRT_EV_NOW: ev_hit = 1'b1;
      PRT_EV_FIELD_ON: ev_hit = rf_ev.field_on;
      PRT_EV_FIELD_OFF: ev_hit = rf_ev.field_off;
      PRT_EV_RX_START: ev_hit = rf_ev.rx_start;
      PRT_EV_RX_END: ev_hit = rf_ev.rx_end;
      PRT_EV_TX_START: ev_hit = rf_ev.tx_start;
      PRT_EV_TX_END: ev_hit = rf_ev.tx_end;
      default: ev_hit = 1'b0;
    endcase
  end

  // Next state of counter, arming and expiry
  always_comb begin
    cfg_d = cfg_q;
    rel_d = rel_q;
    val_d = val_q;
    armed_d = armed_q;
    run_d = run_q;
    exp_d = 1'b0;
    div_d = base_tick ? div_q + 8'h1 : div_q;
    if (armed_q && ev_hit) begin
      armed_d = 1'b0;
      run_d = 1'b1;
      val_d = rel_q;
    end else if (restart && (run_q || armed_q)) begin
      run_d = 1'b1;
      armed_d = 1'b0;
      val_d = rel_q;
    end else if (run_q && tick) begin
      if (val_q <= 20'h1) begin
        exp_d = 1'b1;
        if (cfg_q[PRT_TC_RELOAD]) begin
          val_d = rel_q;
        end else begin
          val_d = 20'h0;
          run_d = 1'b0;
        end
      end else begin
        val_d = val_q - 20'h1;
      end
    end
    if (reload_wr) begin
      rel_d = wdata[19:0];
    end
    if (cfg_wr) begin
      cfg_d = wdata;
      armed_d = wdata[PRT_TC_RUN];
      if (!wdata[PRT_TC_RUN]) begin
        run_d = 1'b0;
      end
    end
    if (clr) begin
      cfg_d = PRT_RST_VAL;
      rel_d = 20'h0;
      val_d = 20'h0;
      armed_d = 1'b0;
      run_d = 1'b0;
      exp_d = 1'b0;
    end
  end

  // Timer registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cfg_q <= 32'h0;
      rel_q <= 20'h0;
      val_q <= 20'h0;
      div_q <= 8'h0;
      armed_q <= 1'b0;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      rel_q <= rel_d;
      val_q <= val_d;
      div_q <= div_d;
      armed_q <= armed_d;
      run_q <= run_d;
      exp_q <= exp_d;
    end
  end

  assign cfg = cfg_q;
  assign reload = rel_q;
  assign value = val_q;
  assign expired = exp_q;
endmodule
`default_nettype wire

//--- rtl/prt_irq.sv
// Sticky interrupt status, enable mask and interrupt pin.
// Assumes strobes from the register decoder are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
module prt_irq (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clr,
  input wire logic [7:0] events,
  input wire logic en_wr,
  input wire logic clr_wr,
  input wire logic stat_rd,
  input wire logic [7:0] wdata,
  input wire logic clear_on_read,
  input wire logic irq_active_high,
  output logic [7:0] status,
  output logic [7:0] enable,
  output logic irq_pin
);
  import prt_pkg::*;

  logic [7:0] stat_q, stat_d, en_q, en_d, kill;
  logic pin_q, pin_d;

  // Flags record always; set wins over clear
  always_comb begin
    kill = 8'h0;
    if (clear_on_read && stat_rd) begin
      kill = stat_q;
    end else if (!clear_on_read && clr_wr) begin
      kill = wdata;
    end
    stat_d = (stat_q & ~kill) | events;
    en_d = en_wr ? wdata : en_q;
    if (clr) begin
      stat_d = events;
      en_d = 8'h0;
    end
    pin_d = (|(stat_q & (en_q | PRT_IRQ_NMI))) ~^ irq_active_high;
  end

  // Status, mask and pin registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stat_q <= 8'h0;
      en_q <= 8'h0;
      pin_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      en_q <= en_d;
      pin_q <= pin_d;
    end
  end

  assign status = stat_q;
  assign enable = en_q;
  assign irq_pin = pin_q;
endmodule
`default_nettype wire

//--- tb/prt_top_props.sv
// Port checker for the controller.
// Assumes binding to prt_top; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module prt_top_props (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic standby_cmd,
  input wire logic [7:0] temp_deg,
  input wire logic card_detect_interrupt,
  input wire logic irq_active_high_cfg,
  input wire logic host_ready,
  input wire logic busy,
  input wire logic irq_pin,
  input wire logic regulators_low_power,
  input wire logic inputs_clamped,
  input wire logic [3:0] pulldown_en,
  input wire logic outputs_hiz,
  input wire logic sinks_low_power,
  input wire logic outputs_hold,
  input wire logic rf_field_on
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========================================================
  // Count of consecutive low cycles on the reset pin
  logic [10:0] low_q;
  logic [10:0] low_d;
  always_comb begin
    low_d = reset_pin_n ? 11'h0 : low_q + 11'(low_q != 11'h7ff);
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) low_q <= 11'h0;
    else low_q <= low_d;
  end
  // ==========================================================
  // Port relations
  property p_busy; host_ready != busy; endproperty
  a_busy: assert property (p_busy) else $error("busy and ready agree");
  property p_pd; regulators_low_power |-> inputs_clamped && outputs_hiz && pulldown_en == 4'hf;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down pins wrong");
  property p_qual; $rose(regulators_low_power) |-> low_q >= 11'd1249; endproperty
  a_qual: assert property (p_qual) else $error("power-down on short pulse");
  property p_exit; regulators_low_power && reset_pin_n |-> ##[1:2] !regulators_low_power;
  endproperty
  a_exit: assert property (p_exit) else $error("power-down not left");
  property p_sb; standby_cmd && host_ready |-> ##[1:3] sinks_low_power && outputs_hold;
  endproperty
  a_sb: assert property (p_sb) else $error("standby not entered");
  property p_sbpd; sinks_low_power |-> !regulators_low_power && !inputs_clamped; endproperty
  a_sbpd: assert property (p_sbpd) else $error("standby clamps inputs");
  property p_hot; temp_deg > 8'h87 |-> ##[1:3] !rf_field_on; endproperty
  a_hot: assert property (p_hot) else $error("field stays on when hot");
  property p_nmi; card_detect_interrupt && irq_active_high_cfg |-> ##[1:3] irq_pin; endproperty
  a_nmi: assert property (p_nmi) else $error("card detect misses pin");
endmodule
bind prt_top prt_top_props u_props (.*);
`default_nettype wire

//--- tb/prt_host_model.sv
// Host model: register strobes, standby and wake.
// Assumes one clock; strobes last one cycle from an edge.
`timescale 1ns/10ps
`default_nettype none
module prt_host_model (
  input wire logic clk_sys,
  input wire logic host_ready,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic standby_cmd,
  output logic host_activity
);
  // ==========================================================
  // Quiet levels at time zero
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, standby_cmd, host_activity} = {2'h0, 8'hff, 34'h0};
  end
  // Bounded wait for ready
  task automatic wait_rdy();
    int n;
    n = 0;
    while (host_ready !== 1'b1 && n < 4000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  // One access; address and data scrambled once released
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wait_rdy();
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Standby or wake pulse
  task automatic pulse(input logic sb);
    @(posedge clk_sys);
    standby_cmd <= sb;
    host_activity <= !sb;
    @(posedge clk_sys);
    standby_cmd <= 1'b0;
    host_activity <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// Bench: start-up, overheat, irq, timer, standby, power-down.
// Assumes the host model drives accesses; a monitor checks reads.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import prt_pkg::*;
  logic clk_sys, reset, reset_pin_n, base_tick, cor, pol, rd_pend;
  logic reg_wr, reg_rd, standby_cmd, host_activity, host_ready, busy, irq_pin;
  logic regulators_low_power, inputs_clamped, outputs_hiz, sinks_low_power;
  logic outputs_hold, card_mode, rf_field_on;
  logic host_io_supply_ok, rf_level_det, noise_event, auth_active;
  logic [2:0] nmi;
  logic [3:0] pulldown_en, tcnt;
  logic [7:0] reg_addr, temp_deg;
  logic [15:0] seed;
  logic [31:0] reg_wdata, reg_rdata, pad_setup, pad_output_levels, v;
  logic [31:0] exp_q[$];
  logic [7:0] th[4] = '{8'd85, 8'd115, 8'd125, 8'd135};
  int err_total, total_checks, cycles;
  prt_host_model u_prt_host_model (.*);
  prt_top #(.STARTUP_CYC(8)) u_prt_top (.*, .rf_ev('0), .card_detect_interrupt(nmi[0]),
    .general_error_ev(nmi[1]), .high_voltage_fault_interrupt(nmi[2]),
    .clear_on_read_cfg(cor), .irq_active_high_cfg(pol));
  // ==========================================================
  // Clock, slow tick and cycle limit
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    tcnt <= (tcnt == 4'h8) ? 4'h0 : tcnt + 4'h1;
    base_tick <= (tcnt == 4'h0);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  // Read monitor
  always @(negedge clk_sys) begin
    if (rd_pend) chk(reg_rdata, exp_q.pop_front());
    rd_pend = reg_rd && host_ready;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_prt_host_model.acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_prt_host_model.acc(1'b0, a, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {reset, reset_pin_n, pol, cor, nmi, tcnt, rd_pend} = {3'b111, 1'b0, 3'h0, 4'h0, 1'b0};
    {host_io_supply_ok, rf_level_det, noise_event, auth_active} = 4'b1000;
    {base_tick, temp_deg, seed, cycles, err_total, total_checks} = {1'b0, 8'h14, 16'd93, 96'h0};
    cyc(4);
    reset <= 1'b0;
    rd(PRT_ADR_IRQ_STAT, 32'h1);
    chk(card_mode, 32'h1);
    seed = lfsr(seed);
    wr(PRT_ADR_PAD_SETUP, {seed, ~seed});
    rd(PRT_ADR_PAD_SETUP, {seed, ~seed});
    wr(PRT_ADR_CHIP_CTRL, 32'h2);
    wr(PRT_ADR_IRQ_CLR, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(PRT_ADR_THERMAL, 32'(i));
      temp_deg <= th[i];
      cyc(3);
      rd(PRT_ADR_IRQ_STAT, 32'h0);
      temp_deg <= th[i] + 8'h1;
      cyc(3);
      chk(irq_pin, 32'h0);
      temp_deg <= 8'h14;
      cyc(3);
      rd(PRT_ADR_IRQ_STAT, 32'h10);
      wr(PRT_ADR_IRQ_CLR, 32'h10);
    end
    chk(rf_field_on, 32'h0);
    temp_deg <= 8'h90;
    wr(PRT_ADR_IRQ_EN, 32'h10);
    cyc(3);
    chk(irq_pin, 32'h1);
    temp_deg <= 8'h14;
    wr(PRT_ADR_IRQ_CLR, 32'h10);
    cyc(3);
    chk(irq_pin, 32'h0);
    cor <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      nmi <= 3'(1 << i);
      cyc(1);
      nmi <= 3'h0;
      cyc(3);
      chk(irq_pin, 32'h1);
      rd(PRT_ADR_IRQ_STAT, 32'(8'h20 << i));
      cyc(3);
      chk(irq_pin, 32'h0);
    end
    cor <= 1'b0;
    pol <= 1'b0;
    cyc(3);
    chk(irq_pin, 32'h1);
    pol <= 1'b1;
    wr(8'h11, 32'h3);
    wr(8'h10, 32'h1);
    cyc(120);
    rd(PRT_ADR_IRQ_STAT, 32'h2);
    rd(8'h12, 32'h0);
    reset_pin_n <= 1'b0;
    cyc(100);
    reset_pin_n <= 1'b1;
    cyc(2);
    chk(host_ready, 32'h1);
    wr(PRT_ADR_CHIP_CTRL, 32'h100);
    cyc(2);
    chk(regulators_low_power, 32'h0);
    rd(PRT_ADR_PAD_SETUP, 32'h0);
    seed = lfsr(seed);
    v = {seed, ~seed};
    wr(PRT_ADR_PAD_SETUP, v);
    wr(PRT_ADR_PAD_OUT, ~v);
    wr(PRT_ADR_THERMAL, 32'h2);
    wr(PRT_ADR_CHIP_CTRL, 32'h1);
    u_prt_host_model.pulse(1'b1);
    cyc(2);
    chk(sinks_low_power, 32'h1);
    chk(pad_setup, v);
    u_prt_host_model.pulse(1'b0);
    rd(PRT_ADR_IRQ_STAT, 32'h1);
    rd(PRT_ADR_PAD_SETUP, v);
    rd(PRT_ADR_PAD_OUT, ~v);
    rd(PRT_ADR_THERMAL, 32'h2);
    rd(PRT_ADR_CHIP_CTRL, 32'h0);
    chk(card_mode, 32'h1);
    reset_pin_n <= 1'b0;
    cyc(1300);
    chk(inputs_clamped, 32'h1);
    chk(32'(pulldown_en), 32'hf);
    reset_pin_n <= 1'b1;
    rd(PRT_ADR_PAD_SETUP, 32'h0);
    cyc(2);
    wrap_up();
  end
endmodule
`default_nettype wire
